// ---- hdl/nfh_consts.svh ----
// constants for the nand flash host pin controller
// assumes a 10 MHz system clock; all pin timing is counted in its cycles
// Function
// - command, address, data share the bus
// - command latch high marks command cycle
// - address latch high marks address cycle
// - hold write guard low during power transitions
// - full address is five cycles, two column
`ifndef NFH_CONSTS_SVH
`define NFH_CONSTS_SVH

// ----------------------------------------
// clock and pin timing
// ----------------------------------------
`define NFH_CLK_MHZ        10
`define NFH_STROBE_NS      100
`define NFH_STROBE_CYC     ((`NFH_STROBE_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_READ_ACCESS_NS 100
`define NFH_READ_ACCESS_CYC ((`NFH_READ_ACCESS_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_FETCH_US       25
`define NFH_PROG_US        320
`define NFH_ERASE_US       1000
`define NFH_FETCH_CYC      (`NFH_FETCH_US * `NFH_CLK_MHZ)
`define NFH_PROG_CYC       (`NFH_PROG_US * `NFH_CLK_MHZ)
`define NFH_ERASE_CYC      (`NFH_ERASE_US * `NFH_CLK_MHZ)

// ----------------------------------------
// geometry
// ----------------------------------------
`define NFH_PAGE_MAIN_X8   2048
`define NFH_PAGE_SPARE_X8  64
`define NFH_PAGE_MAIN_X16  1024
`define NFH_PAGE_SPARE_X16 32
`define NFH_PAGES_PER_BLK  64
`define NFH_BLK_PER_PLANE  2048
`define NFH_PLANES         2
`define NFH_ADDR_CYCLES    5
`define NFH_COL_CYCLES     2

`endif

// ---- hdl/nfh_pkg.sv ----
// types for the nand flash host pin controller
// assumes nfh_consts.svh is on the include path
package nfh_pkg;

  // ----------------------------------------
  // request kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    NFH_OP_CMD  = 2'h0,
    NFH_OP_ADDR = 2'h1,
    NFH_OP_WR   = 2'h2,
    NFH_OP_RD   = 2'h3
  } nfh_op_t;

  typedef struct packed {
    nfh_op_t     op;
    logic [15:0] data;
  } nfh_req_t;

  // pins driven toward the device; io_oe_n low while we drive
  typedef struct packed {
    logic        select_n;
    logic        cmd_latch;
    logic        addr_latch;
    logic        wr_strobe_n;
    logic        rd_strobe_n;
    logic        guard_n;
    logic [15:0] io_out;
    logic        io_oe_n;
  } nfh_pins_t;

  typedef enum logic [2:0] {
    NFH_IDLE  = 3'h0,
    NFH_SETUP = 3'h1,
    NFH_LOW   = 3'h3,
    NFH_HIGH  = 3'h2,
    NFH_DONE  = 3'h6
  } nfh_state_t;

endpackage

// ---- hdl/nfh_timer.sv ----
// cycle counter for strobe phases; one-cycle pulse when a load expires
// assumes a single clock and load values of at least one
`timescale 1ns/1ps
module nfh_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expired
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         run_q, run_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (load) begin
      cnt_d = count;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= W'(1))
        run_d = 1'b0;
      else
        cnt_d = cnt_q - W'(1);
    end
  end

  // expiry must not depend on load: the user reloads on expiry, which would close a loop
  assign expired = run_q && (cnt_q <= W'(1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
endmodule // nfh_timer

// ---- hdl/nfh_host.sv ----
// host-side pin controller for a multiplexed nand flash bus
// assumes pin inputs are synchronous to clk_sys and a user issuing one request at a time
`include "nfh_consts.svh"
`timescale 1ns/1ps
module nfh_host #(
  parameter int IO_W      = 16,
  parameter int STROBE_C  = `NFH_STROBE_CYC,
  parameter int ACCESS_C  = `NFH_READ_ACCESS_CYC
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // user request
  input  wire logic             req_valid,
  input  nfh_pkg::nfh_req_t     req,
  output logic                  req_ready,
  output logic                  rd_valid,
  output logic [15:0]           rd_data,
  // user control
  input  wire logic             wide_bus,
  input  wire logic             allow_write,
  input  wire logic             standby_req,
  output logic                  dev_busy,
  output logic [11:0]           col_count,
  // device pins
  output nfh_pkg::nfh_pins_t    pins,
  input  wire logic [15:0]      io_in,
  input  wire logic             ready_busy_n
);
  import nfh_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  nfh_state_t  st_q, st_d;
  nfh_req_t    cur_q, cur_d;
  nfh_pins_t   pins_q, pins_d;
  logic        rdv_q, rdv_d;
  logic [15:0] rdd_q, rdd_d;
  logic [11:0] col_q, col_d;
  logic [2:0]  acyc_q, acyc_d;
  logic        busy_q, busy_d;
  logic        tload;
  logic [7:0]  tcount;
  logic        texp;

  function automatic logic [15:0] bus_mask(input logic [15:0] v, input logic wide);
    bus_mask = wide ? v : {8'h00, v[7:0]};
  endfunction

  nfh_timer #(.W(8)) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (tload),
    .count   (tcount),
    .expired (texp)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d   = st_q;
    cur_d  = cur_q;
    pins_d = pins_q;
    rdv_d  = 1'b0;
    rdd_d  = rdd_q;
    col_d  = col_q;
    acyc_d = acyc_q;
    busy_d = !ready_busy_n;
    tload  = 1'b0;
    tcount = 8'(STROBE_C);
    // guard stays low unless the user allows writes; this also covers power ramps
    pins_d.guard_n = allow_write;
    case (st_q)
      NFH_IDLE: begin
        pins_d.cmd_latch   = 1'b0;
        pins_d.addr_latch  = 1'b0;
        pins_d.wr_strobe_n = 1'b1;
        pins_d.rd_strobe_n = 1'b1;
        pins_d.io_oe_n     = 1'b1;
        // deselect when idle while standby_req is high so the device can drop to standby
        pins_d.select_n    = standby_req;
        if (req_valid) begin
          cur_d            = req;
          pins_d.select_n  = 1'b0;
          pins_d.cmd_latch  = (req.op == NFH_OP_CMD);
          pins_d.addr_latch = (req.op == NFH_OP_ADDR);
          if (req.op != NFH_OP_RD) begin
            pins_d.io_out  = bus_mask(req.data, wide_bus);
            pins_d.io_oe_n = 1'b0;
          end
          st_d  = NFH_SETUP;
          tload = 1'b1;
        end
      end
      NFH_SETUP: begin
        if (texp) begin
          if (cur_q.op == NFH_OP_RD) begin
            pins_d.rd_strobe_n = 1'b0;
            tcount = 8'(ACCESS_C);
          end else begin
            pins_d.wr_strobe_n = 1'b0;
          end
          tload = 1'b1;
          st_d  = NFH_LOW;
        end
      end
      NFH_LOW: begin
        if (texp) begin
          if (cur_q.op == NFH_OP_RD) begin
            // sample after the access delay, then release the strobe
            rdd_d = bus_mask(io_in, wide_bus);
            rdv_d = 1'b1;
            col_d = col_q + 12'h001;
            pins_d.rd_strobe_n = 1'b1;
          end else begin
            pins_d.wr_strobe_n = 1'b1;
            if (cur_q.op == NFH_OP_CMD)
              acyc_d = 3'h0;
            if (cur_q.op == NFH_OP_ADDR) begin
              // first two address cycles load the column mirror
              if (acyc_q == 3'h0)
                col_d = {col_q[11:8], cur_q.data[7:0]};
              else if (acyc_q == 3'h1)
                col_d = {cur_q.data[3:0], col_q[7:0]};
              acyc_d = (acyc_q == 3'(`NFH_ADDR_CYCLES - 1)) ? 3'h0 : acyc_q + 3'h1;
            end
          end
          tload = 1'b1;
          st_d  = NFH_HIGH;
        end
      end
      NFH_HIGH: begin
        if (texp) begin
          pins_d.cmd_latch  = 1'b0;
          pins_d.addr_latch = 1'b0;
          pins_d.io_oe_n    = 1'b1;
          st_d = NFH_DONE;
        end
      end
      NFH_DONE: begin
        st_d = NFH_IDLE;
      end
      default: st_d = NFH_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= NFH_IDLE;
      cur_q  <= '0;
      pins_q <= '{select_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0, wr_strobe_n: 1'b1,
                  rd_strobe_n: 1'b1, guard_n: 1'b0, io_out: 16'h0000, io_oe_n: 1'b1};
      rdv_q  <= 1'b0;
      rdd_q  <= 16'h0000;
      col_q  <= 12'h000;
      acyc_q <= 3'h0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      pins_q <= pins_d;
      rdv_q  <= rdv_d;
      rdd_q  <= rdd_d;
      col_q  <= col_d;
      acyc_q <= acyc_d;
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      req_ready <= 1'b0;
    else
      req_ready <= (st_d == NFH_IDLE);
  end

  assign pins      = pins_q;
  assign rd_valid  = rdv_q;
  assign rd_data   = rdd_q;
  assign dev_busy  = busy_q;
  assign col_count = col_q;
endmodule // nfh_host

// ---- tb/nfh_monitor.sv ----
// checker for nfh_host pin sequencing
// assumes it is bound onto nfh_host and sees only its ports
`timescale 1ns/1ps
module nfh_monitor
  import nfh_pkg::*;
(
  // watched ports
  input wire logic         clk_sys,
  input wire logic         rst_n,
  input wire logic         allow_write,
  input wire logic         rd_valid,
  input nfh_pkg::nfh_pins_t pins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_strobe_excl: assert property (pins.wr_strobe_n || pins.rd_strobe_n)
    else $error("both strobes low");
  a_latch_excl: assert property (!(pins.cmd_latch && pins.addr_latch))
    else $error("both latch enables high");
  a_cmd_held: assert property (pins.cmd_latch && !pins.wr_strobe_n
    |=> pins.cmd_latch && $stable(pins.io_out)) else $error("command not held at strobe rise");
  a_addr_held: assert property (pins.addr_latch && !pins.wr_strobe_n
    |=> pins.addr_latch && !pins.io_oe_n) else $error("address not held at strobe rise");
  a_guard_low: assert property (!allow_write [*2] |-> !pins.guard_n)
    else $error("guard released while writes barred");
  a_read_release: assert property ($fell(pins.rd_strobe_n) |-> pins.io_oe_n)
    else $error("host drives bus during read");
  a_rd_pulse: assert property (rd_valid |-> $rose(pins.rd_strobe_n))
    else $error("read word without strobe rise");
  c_cmd: cover property (pins.cmd_latch && $rose(pins.wr_strobe_n));
  c_addr: cover property (pins.addr_latch && $rose(pins.wr_strobe_n));
  c_read: cover property (rd_valid);
endmodule // nfh_monitor

bind nfh_host nfh_monitor u_nfh_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
  .allow_write(allow_write), .rd_valid(rd_valid), .pins(pins));

// ---- tb/nfh_dev.sv ----
// behavioural flash device driven by the host pins
// assumes busy times scaled down; holds a 16-word window of one page
`include "nfh_consts.svh"
`timescale 1ns/1ps
module nfh_dev
  import nfh_pkg::*;
#(
  parameter int         BUSY_NS   = 2000, // scaled fetch/program/erase
  parameter int         ACC_NS    = 50,
  parameter logic [7:0] CMD_FETCH = 8'h30,
  parameter logic [7:0] CMD_PROG  = 8'h10,
  parameter logic [7:0] CMD_ERASE = 8'hD0,
  parameter bit         LOCKED    = 1'b0  // lock pin low or floating
) (
  // host pins
  input nfh_pkg::nfh_pins_t pins,
  output logic [15:0]       io_in,
  output logic              ready_busy_n
);
  logic [15:0] mem [16];
  logic [15:0] last;
  logic [11:0] col;
  logic [2:0]  acyc;
  logic [7:0]  c;
  localparam int PAGE_LEN  = `NFH_PAGE_MAIN_X8 + `NFH_PAGE_SPARE_X8;
  // one block is 64 pages, so 128K+4K bytes
  localparam int BLK_PAGES = `NFH_PAGES_PER_BLK;
  localparam int ROWS      = `NFH_PLANES * `NFH_BLK_PER_PLANE * BLK_PAGES;
  logic [$clog2(ROWS)-1:0] row;
  initial begin
    ready_busy_n = 1'b1;
    col = 12'h000;
    acyc = 3'h0;
    last = 16'h0000;
    io_in = 16'hFFFF;
  end
  always @(posedge pins.wr_strobe_n) begin
    c = pins.io_out[7:0];
    if (!pins.select_n) begin
      if (pins.cmd_latch) begin
        acyc = 3'h0;
        if (c == CMD_FETCH || ((c == CMD_PROG || c == CMD_ERASE) && pins.guard_n && !LOCKED)) begin
          ready_busy_n = 1'b0;
          #(BUSY_NS) ready_busy_n = 1'b1;
        end
      end else if (pins.addr_latch) begin
        if (acyc == 3'h0) col[7:0] = c;
        if (acyc == 3'h1) col[11:8] = c[3:0];
        if (acyc == 3'h2) row[7:0] = c;
        if (acyc == 3'h3) row[15:8] = c;
        if (acyc == 3'h4) row[17:16] = c[1:0]; // row spans both planes
        acyc = acyc + 3'h1;
      end else begin
        mem[col[3:0]] = pins.io_out;
        col = (col == 12'(PAGE_LEN - 1)) ? 12'h000 : col + 12'h001;
      end
    end
  end
  always @(negedge pins.rd_strobe_n) begin
    if (!pins.select_n) begin
      last = mem[col[3:0]];
      col = col + 12'h001;
      io_in = ~last;
      #(ACC_NS) io_in = last;
    end
  end
  // released bus shows the inverse so stale data never passes
  always @(posedge pins.rd_strobe_n or posedge pins.select_n) io_in = ~last;
endmodule // nfh_dev

// ---- tb/testbench.sv ----
// self-checking bench for nfh_host against a behavioural device
// assumes nfh_dev as far side and nfh_monitor bound to the host
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import nfh_pkg::*;
  typedef struct packed { nfh_op_t op; logic [15:0] d; logic [15:0] e; } nfh_row_t;
  logic        clk_sys, rst_n, req_valid, req_ready, rd_valid, wide_bus, allow_write;
  logic        standby_req, dev_busy, ready_busy_n, saw_busy;
  logic [15:0] rd_data, io_in;
  logic [11:0] col_count;
  nfh_req_t    req;
  nfh_pins_t   pins;
  int          fail_count, cmp_count, cyc, rdv_count;
  nfh_row_t rows [10] = '{'{NFH_OP_CMD, 16'h0080, 16'h0}, '{NFH_OP_ADDR, 16'h0002, 16'h0},
    '{NFH_OP_WR, 16'hA55A, 16'h0}, '{NFH_OP_WR, 16'h3CC3, 16'h0},
    '{NFH_OP_CMD, 16'h0010, 16'h1}, '{NFH_OP_CMD, 16'h0000, 16'h0},
    '{NFH_OP_ADDR, 16'h0002, 16'h0}, '{NFH_OP_CMD, 16'h0030, 16'h1},
    '{NFH_OP_RD, 16'h0, 16'hA55A}, '{NFH_OP_RD, 16'h0, 16'h3CC3}};
  nfh_host u_nfh_host (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .wide_bus(wide_bus),
    .allow_write(allow_write), .standby_req(standby_req), .dev_busy(dev_busy),
    .col_count(col_count), .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nfh_dev u_nfh_dev (.pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // cut a hang short; tests need well under this
  always @(posedge clk_sys) begin
    cyc++;
    if (dev_busy === 1'b1) saw_busy <= 1'b1;
    if (rd_valid === 1'b1) rdv_count++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic do_req(input nfh_op_t op, input logic [15:0] d);
    req_valid <= 1'b1;
    req <= '{op, d};
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    saw_busy = 1'b0;
    do @(posedge clk_sys); while (req_ready !== 1'b1 || ready_busy_n !== 1'b1 || dev_busy !== 1'b0);
  endtask
  task automatic addr5(input logic [15:0] a);
    do_req(NFH_OP_ADDR, {8'h00, a[7:0]});
    do_req(NFH_OP_ADDR, {8'h00, a[15:8]});
    repeat (3) do_req(NFH_OP_ADDR, 16'h0000);
  endtask
  initial begin
    {rst_n, req_valid, standby_req, saw_busy} = 4'h0;
    {wide_bus, allow_write} = 2'b11;
    req = '0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].op == NFH_OP_ADDR) begin
        addr5(rows[i].d);
        `CHK("col", rows[i].d[11:0], col_count)
      end else do_req(rows[i].op, rows[i].d);
      if (rows[i].op == NFH_OP_RD || rows[i].op == NFH_OP_CMD)
        `CHK("row", rows[i].e, (rows[i].op == NFH_OP_RD) ? rd_data : {15'h0, saw_busy})
    end
    `CHK("col_rd", 12'h004, col_count)
    allow_write <= 1'b0;
    do_req(NFH_OP_CMD, 16'h0080);
    do_req(NFH_OP_CMD, 16'h0010);
    `CHK("guard", 1'b0, pins.guard_n)
    `CHK("lockout", 1'b0, saw_busy)
    wide_bus <= 1'b0;
    do_req(NFH_OP_CMD, 16'h0000);
    addr5(16'h0002);
    do_req(NFH_OP_CMD, 16'h0030);
    do_req(NFH_OP_RD, 16'h0000);
    `CHK("narrow", 16'h005A, rd_data)
    `CHK("rd_pulses", 3, rdv_count)
    standby_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("standby", 1'b1, pins.select_n)
    rst_n <= 1'b0;
    @(posedge clk_sys);
    `CHK("rst", 4'hA, {pins.select_n, pins.guard_n, pins.io_oe_n, req_ready})
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("rel", 13'h1000, {req_ready, col_count})
    give_verdict();
  end
endmodule // testbench
